// ### hw/suc_utility.sv
// Notes on behaviour
// RULE_01: host sends 1Dh with FFh parameter byte
// RULE_02: isolation bit 0 isolated, 1 enabled
// RULE_03: level bit reports sampled pin level
// RULE_04: level meaningful only for enabled buffers
// RULE_05: free pins only; no effect in four-wire mode
// RULE_06: ignore host traffic; strong pullup held active
// RULE_07: delay opcode DDh, exponent in bits 3:0
// RULE_08: pause two to exponent milliseconds
// RULE_09: CCh switches peripheral supply on
// RULE_10: supply released when sequence duration ends
// RULE_11: host adds delays to hold supply longer
// RULE_12: BBh switches peripheral supply off
// RULE_13: reserved bits ignored; next opcode after delay
module suc_utility
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire suc_pkg::suc_cmd_t    cmd,
  output logic                      cmd_ready,
  output suc_pkg::suc_result_t      result,
  input  wire logic                 seq_active,
  input  wire logic                 four_wire_mode,
  input  wire logic [3:0]           pin_free,
  input  wire logic [3:0]           pin_buf_en,
  input  wire logic [3:0]           pin_level,
  output logic                      host_accept,
  output logic                      strong_pullup,
  output logic                      peripheral_supply_output,
  output logic                      peripheral_supply_oe_b
);
  import suc_pkg::*;

  suc_state_t  state_r,   state_nxt;
  // one millisecond is a fixed count of clocks; a faster clock would need a wider counter
  logic [16:0] ms_cnt_r,  ms_cnt_nxt;
  // milliseconds still to run; sixteen bits hold two to the fifteenth
  logic [15:0] ms_left_r, ms_left_nxt;
  logic        supply_r,  supply_nxt;
  suc_result_t res_r,     res_nxt;
  logic        busy;
  logic [7:0]  buf_byte;
  wire  [3:0]  iso_bits;
  wire  [3:0]  lvl_bits;

  // decoding of a taken opcode, shared by the checks below
  function automatic logic op_taken(input suc_cmd_t c, input logic rdy, input logic [7:0] op);
    return c.valid && rdy && (c.opcode == op);
  endfunction : op_taken

  // only free pins report; claimed pins read as isolated and low
  for (genvar pin = 0; pin < NUM_PINS; pin++)
  begin : g_pin
    assign iso_bits[pin] = pin_buf_en[pin] & pin_free[pin];   // [RULE_02] [RULE_05]
    // an isolated buffer gives no level, so a floating pin never shows up as high
    assign lvl_bits[pin] = pin_level[pin] & iso_bits[pin];    // [RULE_03] [RULE_04]
  end : g_pin

  always_comb
  begin
    buf_byte                      = BYTE_ZERO;
    buf_byte[ISO_LSB +: NUM_PINS] = iso_bits;
    buf_byte[LVL_LSB +: NUM_PINS] = lvl_bits;
  end

  assign busy          = (state_r != SUC_IDLE) || cmd.valid;
  assign cmd_ready     = (state_r == SUC_IDLE);
  assign host_accept   = !busy;            // [RULE_06]
  assign strong_pullup = busy;             // [RULE_06]
  assign result        = res_r;
  assign peripheral_supply_output = supply_r;
  // released (high impedance) whenever the supply is not switched on
  assign peripheral_supply_oe_b   = !supply_r;

  always_comb
  begin
    state_nxt   = state_r;
    ms_cnt_nxt  = ms_cnt_r;
    ms_left_nxt = ms_left_r;
    supply_nxt  = supply_r;
    res_nxt     = '{valid: 1'b0, data: BYTE_ZERO};
    unique case (state_r)
      SUC_IDLE:
      begin
        if (cmd.valid)
        begin
          state_nxt = SUC_DONE;
          unique case (cmd.opcode)
            OP_BUF_READ:
            begin
              // four-wire mode leaves the parameter byte untouched
              if (four_wire_mode)                                // [RULE_05]
                res_nxt = '{valid: 1'b1, data: cmd.param};
              else                                               // [RULE_01]
                res_nxt = '{valid: 1'b1,
                            data: buf_byte};
            end
            OP_DELAY:
            begin
              // upper nibble is reserved and never enters the count
              state_nxt   = SUC_DELAY;                           // [RULE_07] [RULE_13]
              ms_cnt_nxt  = MS_CYCLES - 17'h00001;
              ms_left_nxt = 16'h0001 << cmd.param[DLY_EXP_LSB +: DLY_EXP_W]; // [RULE_08]
            end
            OP_SUPPLY_ON:  supply_nxt = 1'b1;                    // [RULE_09]
            OP_SUPPLY_OFF: supply_nxt = 1'b0;                    // [RULE_12]
            default:       state_nxt = SUC_DONE;
          endcase
        end
      end
      SUC_DELAY:
      begin
        if (ms_cnt_r == 17'h00000)
        begin
          ms_cnt_nxt  = MS_CYCLES - 17'h00001;
          ms_left_nxt = ms_left_r - 16'h0001;
          if (ms_left_r == 16'h0001)
            state_nxt = SUC_DONE;                                // [RULE_13]
        end
        else
          ms_cnt_nxt = ms_cnt_r - 17'h00001;
      end
      SUC_DONE: state_nxt = SUC_IDLE;
      default:  state_nxt = SUC_IDLE;
    endcase
    // sequence end outranks an on opcode in the same cycle, so the rail never outlives it
    if (!seq_active)
      supply_nxt = 1'b0;                                         // [RULE_10]
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r   <= SUC_IDLE;
      ms_cnt_r  <= 17'h00000;
      ms_left_r <= 16'h0000;
      supply_r  <= 1'b0;
      res_r     <= '{valid: 1'b0, data: BYTE_ZERO};
    end
    else
    begin
      state_r   <= state_nxt;
      ms_cnt_r  <= ms_cnt_nxt;
      ms_left_r <= ms_left_nxt;
      supply_r  <= supply_nxt;
      res_r     <= res_nxt;
    end
  end

  a_supply_on: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_09]
    op_taken(cmd, cmd_ready, OP_SUPPLY_ON) && seq_active
    |=> peripheral_supply_output)
    else $error("supply not on after on opcode");
  a_supply_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_12]
    op_taken(cmd, cmd_ready, OP_SUPPLY_OFF)
    |=> !peripheral_supply_output)
    else $error("supply not off after off opcode");
  a_supply_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_10]
    !seq_active |=> peripheral_supply_oe_b)
    else $error("supply still driven after sequence end");
  a_oe_track: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_10]
    peripheral_supply_oe_b == !peripheral_supply_output)
    else $error("supply enable and level disagree");
  // the rail stays up across other opcodes, delays included, until switched off or the sequence ends
  a_supply_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_09]
    peripheral_supply_output && seq_active && !op_taken(cmd, cmd_ready, OP_SUPPLY_OFF)
    |=> peripheral_supply_output)
    else $error("supply dropped without off opcode");

  a_busy_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_06]
    (state_r == SUC_DELAY) |-> !host_accept && strong_pullup)
    else $error("host traffic accepted while busy");
  a_take_busy: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_06]
    (cmd.valid || (state_r != SUC_IDLE)) |-> (!host_accept && strong_pullup))
    else $error("host traffic accepted while a command runs");

  a_read_iso: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_02]
    op_taken(cmd, cmd_ready, OP_BUF_READ) && !four_wire_mode
    |=> result.valid && result.data[ISO_LSB +: NUM_PINS] == $past(pin_buf_en & pin_free))
    else $error("isolation bits wrong");
  a_read_lvl: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_03]
    op_taken(cmd, cmd_ready, OP_BUF_READ) && !four_wire_mode
    |=> result.data[LVL_LSB +: NUM_PINS] == $past(pin_level & pin_buf_en & pin_free))
    else $error("level bits wrong");
  // in four-wire mode the byte goes back as it came
  a_read_spi: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_05]
    op_taken(cmd, cmd_ready, OP_BUF_READ) && four_wire_mode
    |=> result.data == $past(cmd.param))
    else $error("read changed byte in four-wire mode");
  a_read_only: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_02]
    result.valid |-> $past(op_taken(cmd, cmd_ready, OP_BUF_READ)))
    else $error("result byte without read opcode");
  a_read_ready: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_06]
    op_taken(cmd, cmd_ready, OP_BUF_READ) |=> !cmd_ready ##1 cmd_ready)
    else $error("read did not hold off the next opcode");

  a_delay_min: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_13]
    op_taken(cmd, cmd_ready, OP_DELAY)
    |=> (state_r == SUC_DELAY) [*8])
    else $error("delay ended early");
  // upper nibble of the parameter must never reach the count
  a_delay_load: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_08] [RULE_13]
    op_taken(cmd, cmd_ready, OP_DELAY)
    |=> (ms_left_r == (16'h0001 << $past(cmd.param[DLY_EXP_LSB +: DLY_EXP_W])))
        && (ms_cnt_r == MS_CYCLES - 17'h00001))
    else $error("delay loaded with wrong length");
  a_ms_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_13]
    (state_r == SUC_DELAY) && (ms_cnt_r != 17'h00000)
    |=> (state_r == SUC_DELAY) && (ms_cnt_r == $past(ms_cnt_r) - 17'h00001))
    else $error("delay left before the millisecond ran out");
  a_ms_reload: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_08]
    (state_r == SUC_DELAY) && (ms_cnt_r == 17'h00000)
    |=> (ms_cnt_r == MS_CYCLES - 17'h00001)
        && (ms_left_r == $past(ms_left_r) - 16'h0001))
    else $error("millisecond count not reloaded");
  a_delay_end: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_13]
    (state_r == SUC_DELAY) && (ms_cnt_r == 17'h00000) && (ms_left_r == 16'h0001)
    |=> (state_r == SUC_DONE) ##1 cmd_ready)
    else $error("next opcode not allowed after delay");
endmodule : suc_utility

// ### hw/suc_pkg.sv
package suc_pkg;
  localparam logic [7:0] OP_BUF_READ   = 8'h1D;
  localparam logic [7:0] OP_DELAY      = 8'hDD;
  localparam logic [7:0] OP_SUPPLY_ON  = 8'hCC;
  localparam logic [7:0] OP_SUPPLY_OFF = 8'hBB;
  localparam logic [7:0] BUF_READ_FILL = 8'hFF;
  localparam int         DLY_EXP_LSB   = 0;
  localparam int         DLY_EXP_W     = 4;
  localparam int         ISO_LSB       = 4;
  localparam int         LVL_LSB       = 0;
  localparam int         NUM_PINS      = 4;
  localparam int         CLK_MHZ       = 125;
  localparam int         MS_NS         = 1000000;
  localparam int         CLK_NS        = 8;
  localparam logic [16:0] MS_CYCLES    = 17'(MS_NS / CLK_NS);
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] param;
  } suc_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } suc_result_t;

  typedef enum logic [2:0] {
    SUC_IDLE  = 3'b001,
    SUC_DELAY = 3'b010,
    SUC_DONE  = 3'b100
  } suc_state_t;
endpackage : suc_pkg

// ### dv/suc_pin_model.sv
module suc_pin_model
(
  input  wire logic       ref_clk,
  input  wire logic [3:0] pin_buf_en,
  output logic      [3:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] flick_r = 4'h5;
  // isolated pins toggle so a stale level never passes for a real one
  always @(posedge ref_clk) flick_r <= ~flick_r;
  assign pin_level = (4'hA & pin_buf_en) | (flick_r & ~pin_buf_en);
endmodule : suc_pin_model

// ### dv/suc_utility_tb_top.sv
module suc_utility_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import suc_pkg::*;
  logic        ref_clk = 0, rst_b = 0, seq_active = 0, four_wire_mode = 0;
  suc_cmd_t    cmd = '0;
  logic [3:0]  pin_free = 4'h7, pin_buf_en = 4'hE, pin_level;
  logic        cmd_ready, host_accept, strong_pullup, sup, sup_oe_b, acc, pullup_seen;
  suc_result_t result, res;
  int          bad_count = 0, n_compared = 0, n;
  always #4 ref_clk = ~ref_clk;
  suc_pin_model i_pins (.ref_clk(ref_clk), .pin_buf_en(pin_buf_en), .pin_level(pin_level));
  suc_utility i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .cmd_ready(cmd_ready),
    .result(result), .seq_active(seq_active), .four_wire_mode(four_wire_mode),
    .pin_free(pin_free), .pin_buf_en(pin_buf_en), .pin_level(pin_level),
    .host_accept(host_accept), .strong_pullup(strong_pullup),
    .peripheral_supply_output(sup), .peripheral_supply_oe_b(sup_oe_b));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // n counts edges from the taking edge until ready is back
  task automatic send(input logic [7:0] op, input logic [7:0] p);
    @(posedge ref_clk) cmd <= '{1'b1, op, p};
    @(posedge ref_clk) cmd <= '0;
    #1;
    res = result;
    acc = host_accept;
    pullup_seen = strong_pullup;
    n = 1;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge ref_clk) #1;
      n++;
      if (n > 130000)
      begin
        bad_count++;
        end_of_test();
      end
    end
  endtask : send
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1;
    seq_active <= 1;
    send(OP_BUF_READ, BUF_READ_FILL);
    chk("result valid", res.valid, 1);
    chk("buffer byte", res.data, 8'h62);
    chk("host accept", acc, 0);
    chk("strong pullup", pullup_seen, 1);
    chk("ready gap", n, 2);
    chk("idle accept", host_accept, 1);
    $display("buffer read done");
    @(posedge ref_clk) four_wire_mode <= 1;
    send(OP_BUF_READ, BUF_READ_FILL);
    chk("four wire valid", res.valid, 1);
    chk("four wire byte", res.data, 8'hFF);
    @(posedge ref_clk) four_wire_mode <= 0;
    $display("four wire read done");
    // an opcode outside this set takes the short path and changes nothing
    send(8'h5A, BYTE_ZERO);
    chk("unknown gap", n, 2);
    chk("unknown result", res.valid, 0);
    chk("unknown supply", {sup, sup_oe_b}, 2'b01);
    $display("unknown opcode done");
    send(OP_SUPPLY_ON, BYTE_ZERO);
    chk("supply on", {sup, sup_oe_b}, 2'b10);
    send(OP_SUPPLY_OFF, BYTE_ZERO);
    chk("supply off", {sup, sup_oe_b}, 2'b01);
    send(OP_SUPPLY_ON, BYTE_ZERO);
    @(posedge ref_clk) seq_active <= 0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("supply release", {sup, sup_oe_b}, 2'b01);
    @(posedge ref_clk) seq_active <= 1;
    $display("supply tests done");
    send(OP_SUPPLY_ON, BYTE_ZERO);
    // reserved bits set with exponent zero: one millisecond, with the supply kept up across it
    send(OP_DELAY, 8'hF0);
    chk("delay cycles", n, 125002);
    chk("delay pullup", pullup_seen, 1);
    chk("delay accept", acc, 0);
    chk("supply held", {sup, sup_oe_b}, 2'b10);
    $display("delay test done");
    @(posedge ref_clk) rst_b <= 0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("reset supply", {sup, sup_oe_b}, 2'b01);
    chk("reset ready", cmd_ready, 1);
    chk("reset result", result.valid, 0);
    @(posedge ref_clk) rst_b <= 1;
    send(OP_BUF_READ, BUF_READ_FILL);
    chk("read after reset", res.data, 8'h62);
    $display("reset test done");
    end_of_test();
  end
endmodule : suc_utility_tb_top
